// ---- hw/csso_stack_ops.sv ----
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Function
// - select 0: store destination at stack pointer plus unsigned word offset
// - select 1: load word from stack pointer plus offset into destination
// - eight-bit word offset is shifted left two, ten-bit byte offset
// - load-address select 0 writes program counter plus offset to destination
// - load-address select 1 writes stack pointer plus offset to destination
// - program counter source is instruction address plus four, bit one cleared
// - load-address leaves condition flags unchanged
// - stack adjust adds offset when sign clear, subtracts when set
// - seven-bit magnitude shifted left two, range plus or minus 508
// - stack adjust leaves condition flags unchanged
// - full-descending stack: push pre-decrements, final pointer written back
// - list covers registers 0-7; extra bit adds link or program counter
// - push with extra bit stores link register and updates stack pointer
// - pop loads upward from stack pointer, writes incremented pointer back
// - pop with extra bit loads program counter, redirecting execution
// - multiple store writes list upward from base, writes base back
// - multiple load reads list upward from base, writes base back unless the base is in the list
// - cycle count matches the equivalent full-width instruction
module csso_stack_ops
  import csso_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output csso_mem_s memReq,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic busy,
  output logic pcRedirect
);

  //////////////////////////////////////////////////////////////////////////////
  // software-visible state
  logic [31:0] regs_r [16];
  logic [15:0] instr_r;
  logic [31:0] iaddr_r;
  logic [3:0] flags_r;
  logic start_r;
  logic [31:0] pcOut_r;
  logic redirect_r;
  csso_state_e state_r;
  csso_mem_s mem_r;
  logic [8:0] todo_r;
  logic [31:0] ptr_r;
  logic [31:0] newBase_r;
  logic [3:0] baseIdx_r;
  logic isLoad_r;
  logic wbBase_r;

  logic apbWr;
  logic apbRd;
  logic regSel;
  logic [3:0] regIdx;
  assign apbWr = psel && penable && pwrite && clkEn;
  assign apbRd = psel && penable && !pwrite;
  assign regSel = paddr >= ADDR_REG0 && paddr <= ADDR_REG_TOP && paddr[1:0] == 2'h0;
  assign regIdx = paddr[5:2];
  // zero wait states; writes refused while an instruction runs
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(regSel || paddr == ADDR_INSTR
    || paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_IADDR
    || paddr == ADDR_RDATA || paddr == ADDR_FLAGS || paddr == ADDR_PCOUT);

  always_comb
  begin
    prdata = RESET_WORD;
    if (apbRd)
    begin
      if (regSel)
        prdata = regs_r[regIdx];
      else
        case (paddr)
          ADDR_INSTR: prdata = {16'h0000, instr_r};
          ADDR_STATUS: prdata = {29'h0, redirect_r, state_r != CSSO_IDLE, 1'b0};
          ADDR_IADDR: prdata = iaddr_r;
          ADDR_FLAGS: prdata = {28'h0, flags_r};
          ADDR_PCOUT: prdata = pcOut_r;
          default: prdata = RESET_WORD;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode, published field layout
  csso_dec_s dec;
  logic selBit;
  logic [2:0] rdField;
  logic [7:0] rlist;
  logic extraBit;
  logic [31:0] wordOff;
  logic [31:0] adjOff;
  logic [31:0] pcBase;
  logic [3:0] listCount;
  logic [8:0] fullList;

  always_comb
  begin
    dec.isSpRel = instr_r[15:12] == OP_SPREL;
    dec.isLdAddr = instr_r[15:12] == OP_LDADDR;
    dec.isSpAdj = instr_r[15:8] == OP_SPADJ;
    dec.isPushPop = instr_r[15:12] == OP_PUSHPOP && instr_r[10:9] == 2'b10;
    dec.isMulti = instr_r[15:12] == OP_MULTI;
  end
  assign selBit = instr_r[11];
  assign rdField = instr_r[10:8];
  assign rlist = instr_r[7:0];
  assign extraBit = instr_r[8];
  assign wordOff = {22'h0, instr_r[7:0], 2'b00};
  assign adjOff = {23'h0, instr_r[6:0], 2'b00};
  assign pcBase = (iaddr_r + PC_AHEAD) & ~32'h0000_0002;
  assign fullList = (dec.isPushPop && extraBit) ? {1'b1, rlist} : {1'b0, rlist};

  always_comb
  begin
    listCount = 4'h0;
    for (int i = 0; i < 9; i++)
      listCount = listCount + {3'h0, fullList[i]};
  end

  // next listed register, lowest first; bit 8 maps to link or program counter
  logic [3:0] nextIdx;
  logic [8:0] nextBit;
  always_comb
  begin
    nextIdx = 4'h0;
    nextBit = 9'h0;
    for (int i = 8; i >= 0; i--)
      if (todo_r[i])
      begin
        nextIdx = (i == 8) ? (isLoad_r ? PC_IDX : LR_IDX) : 4'(i);
        nextBit = 9'h1 << i;
      end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: one memory word per access, as the full-width form does
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= CSSO_IDLE;
      mem_r <= '0;
      todo_r <= 9'h0;
      ptr_r <= RESET_WORD;
      newBase_r <= RESET_WORD;
      baseIdx_r <= 4'h0;
      isLoad_r <= 1'b0;
      wbBase_r <= 1'b0;
      redirect_r <= 1'b0;
      pcOut_r <= RESET_WORD;
      for (int i = 0; i < 16; i++)
        regs_r[i] <= RESET_WORD;
    end
    else if (clkEn)
    begin
      redirect_r <= 1'b0;
      if (apbWr && regSel && state_r == CSSO_IDLE)
        regs_r[regIdx] <= pwdata;
      case (state_r)
        CSSO_IDLE:
          if (start_r)
            state_r <= CSSO_EXEC;
        CSSO_EXEC:
        begin
          state_r <= CSSO_IDLE;
          wbBase_r <= 1'b0;
          if (dec.isSpRel)
          begin
            mem_r.addr <= regs_r[SP_IDX] + wordOff;
            mem_r.wr <= !selBit;
            mem_r.wdata <= regs_r[{1'b0, rdField}];
            isLoad_r <= selBit;
            todo_r <= 9'h0;
            baseIdx_r <= {1'b0, rdField};
            state_r <= CSSO_MEMREQ;
          end
          else if (dec.isLdAddr)
            // flags untouched on purpose
            regs_r[{1'b0, rdField}] <= (selBit ? regs_r[SP_IDX] : pcBase)
              + wordOff;
          else if (dec.isSpAdj)
            regs_r[SP_IDX] <= instr_r[7] ? regs_r[SP_IDX] - adjOff
              : regs_r[SP_IDX] + adjOff;
          else if ((dec.isPushPop || dec.isMulti) && fullList != 9'h0)
          begin
            isLoad_r <= selBit;
            todo_r <= fullList;
            wbBase_r <= 1'b1;
            if (dec.isPushPop)
            begin
              baseIdx_r <= SP_IDX;
              if (selBit)
              begin
                ptr_r <= regs_r[SP_IDX];
                newBase_r <= regs_r[SP_IDX] + {26'h0, listCount, 2'b00};
              end
              else
              begin
                // full descending: lowest register ends at lowest address
                ptr_r <= regs_r[SP_IDX] - {26'h0, listCount, 2'b00};
                newBase_r <= regs_r[SP_IDX] - {26'h0, listCount, 2'b00};
              end
            end
            else
            begin
              baseIdx_r <= {1'b0, rdField};
              ptr_r <= regs_r[{1'b0, rdField}];
              newBase_r <= regs_r[{1'b0, rdField}] + {26'h0, listCount, 2'b00};
            end
            state_r <= CSSO_MEMREQ;
          end
        end
        CSSO_MEMREQ:
        begin
          mem_r.req <= 1'b1;
          if (todo_r != 9'h0)
          begin
            mem_r.addr <= ptr_r;
            mem_r.wr <= !isLoad_r;
            mem_r.wdata <= regs_r[nextIdx];
            baseIdx_r <= wbBase_r ? baseIdx_r : baseIdx_r;
          end
          state_r <= CSSO_MEMWAIT;
        end
        CSSO_MEMWAIT:
          if (memAck)
          begin
            mem_r.req <= 1'b0;
            if (todo_r == 9'h0)
            begin
              if (isLoad_r)
                regs_r[baseIdx_r] <= memRdata;
              state_r <= CSSO_IDLE;
            end
            else
            begin
              if (isLoad_r)
              begin
                regs_r[nextIdx] <= memRdata;
                if (nextIdx == PC_IDX)
                begin
                  pcOut_r <= memRdata;
                  redirect_r <= 1'b1;
                end
              end
              todo_r <= todo_r & ~nextBit;
              ptr_r <= ptr_r + WORD_BYTES;
              state_r <= ((todo_r & ~nextBit) == 9'h0) ? CSSO_WBACK : CSSO_MEMREQ;
            end
          end
        CSSO_WBACK:
        begin
          // loaded base keeps loaded value, as the full-width form leaves it
          if (!(isLoad_r && baseIdx_r != SP_IDX && fullList[baseIdx_r[2:0]]))
            regs_r[baseIdx_r] <= newBase_r;
          state_r <= CSSO_IDLE;
        end
        default: state_r <= CSSO_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction issue and flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_r <= 16'h0000;
      iaddr_r <= RESET_WORD;
      start_r <= 1'b0;
    end
    else if (clkEn)
    begin
      start_r <= 1'b0;
      if (apbWr && state_r == CSSO_IDLE)
      begin
        if (paddr == ADDR_INSTR)
          instr_r <= pwdata[15:0];
        if (paddr == ADDR_IADDR)
          iaddr_r <= pwdata;
        if (paddr == ADDR_CTRL)
          start_r <= pwdata[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_r <= 4'h0;
    else if (clkEn && apbWr && paddr == ADDR_FLAGS && state_r == CSSO_IDLE)
      flags_r <= pwdata[3:0];
  end

  assign memReq = mem_r;
  assign busy = state_r != CSSO_IDLE || start_r;
  assign pcRedirect = redirect_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == CSSO_EXEC && (dec.isLdAddr || dec.isSpAdj) |=> flags_r == $past(flags_r))
    else $error("flags changed by address or stack adjust");
  a_spadj_value: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && state_r == CSSO_EXEC && dec.isSpAdj |=> regs_r[SP_IDX] ==
    ($past(instr_r[7]) ? $past(regs_r[SP_IDX]) - $past(adjOff)
    : $past(regs_r[SP_IDX]) + $past(adjOff)))
    else $error("stack adjust result wrong");
  a_ldaddr_pc: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && state_r == CSSO_EXEC && dec.isLdAddr && !selBit |=>
    regs_r[$past(rdField)][1:0] == 2'b00)
    else $error("pc-relative address not word aligned");
  a_sprel_addr: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && state_r == CSSO_EXEC && dec.isSpRel |=>
    mem_r.addr == $past(regs_r[SP_IDX]) + $past(wordOff) && mem_r.wr == !$past(selBit))
    else $error("stack relative address wrong");
  a_offset_range: assert property (@(posedge clk) disable iff (!rst_n)
    wordOff <= 32'd1020 && adjOff <= 32'd508)
    else $error("offset out of range");
  a_push_addr: assert property (@(posedge clk) disable iff (!rst_n)
    mem_r.req && mem_r.wr && baseIdx_r == SP_IDX && wbBase_r |->
    (mem_r.addr - newBase_r) < (regs_r[SP_IDX] - newBase_r))
    else $error("push wrote above stack pointer");
  a_redirect_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    redirect_r |-> ##1 !redirect_r || !$past(clkEn))
    else $error("redirect longer than one cycle");
  a_wback_idle: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && state_r == CSSO_WBACK |=> state_r == CSSO_IDLE)
    else $error("write back did not finish");
  c_push: cover property (@(posedge clk) state_r == CSSO_EXEC && dec.isPushPop && !selBit);
  c_pop_pc: cover property (@(posedge clk) redirect_r);
  c_multi: cover property (@(posedge clk) state_r == CSSO_EXEC && dec.isMulti);
  c_spadj: cover property (@(posedge clk) state_r == CSSO_EXEC && dec.isSpAdj);

endmodule : csso_stack_ops
`default_nettype wire

// ---- hw/csso_pkg.sv ----
package csso_pkg;

  // register indices of note
  localparam logic [3:0] SP_IDX = 4'hd;
  localparam logic [3:0] LR_IDX = 4'he;
  localparam logic [3:0] PC_IDX = 4'hf;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam int OFFSET_SHIFT = 2;

  // apb map of the core-facing block
  localparam logic [11:0] ADDR_INSTR = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IADDR = 12'h00c;
  localparam logic [11:0] ADDR_RDATA = 12'h010;
  localparam logic [11:0] ADDR_REG0 = 12'h040;
  localparam logic [11:0] ADDR_REG_TOP = 12'h07c;
  localparam logic [11:0] ADDR_FLAGS = 12'h080;
  localparam logic [11:0] ADDR_PCOUT = 12'h084;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // opcode top bits of each format
  localparam logic [3:0] OP_SPREL = 4'h9;
  localparam logic [3:0] OP_LDADDR = 4'ha;
  localparam logic [7:0] OP_SPADJ = 8'hb0;
  localparam logic [3:0] OP_PUSHPOP = 4'hb;
  localparam logic [3:0] OP_MULTI = 4'hc;

  typedef enum logic [2:0] {
    CSSO_IDLE = 3'b000,
    CSSO_EXEC = 3'b001,
    CSSO_MEMREQ = 3'b010,
    CSSO_MEMWAIT = 3'b011,
    CSSO_WBACK = 3'b100
  } csso_state_e;

  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } csso_mem_s;

  typedef struct packed {
    logic isSpRel;
    logic isLdAddr;
    logic isSpAdj;
    logic isPushPop;
    logic isMulti;
  } csso_dec_s;

endpackage : csso_pkg

// ---- test/csso_stack_ops_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import csso_pkg::*;
  logic clk, rst_n, clkEn, psel, penable, pwrite, memAck, pready, pslverr, busy, pcRedirect;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, memRdata, rd, ma, md, ia, fl, expPc;
  logic err, mw, s, expR;
  logic [15:0] ins, w;
  csso_mem_s memReq;
  int bad_count, check_count, cyc, redir, dly, n, i;
  logic [31:0] mem[logic [31:0]];
  logic [31:0] qA[$], qD[$], ini[16], mdl[16];
  logic qW[$];

  csso_stack_ops uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .busy(busy),
    .pcRedirect(pcRedirect));

  ////////////////////////////////////////////////////////////////////////////////
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  ////////////////////////////////////////////////////////////////////////////////
  // expected memory traffic is queued in order, the responder checks it
  task put(input logic [31:0] a, input logic [31:0] d);
    qA.push_back(a);
    qW.push_back(1'b1);
    qD.push_back(d);
  endtask : put

  function automatic logic [31:0] rdMem(input logic [31:0] a);
    if (!mem.exists(a)) mem[a] = $urandom;
    qA.push_back(a);
    qW.push_back(1'b0);
    qD.push_back(32'h0);
    return mem[a];
  endfunction : rdMem

  task model();
    logic [31:0] a, wb, off;
    int cnt;
    mdl = ini;
    off = {22'h0, ins[7:0], 2'b00};
    expR = 1'b0;
    case (ins[15:12])
      4'h9:
      begin
        a = mdl[13] + off;
        if (ins[11]) mdl[ins[10:8]] = rdMem(a);
        else put(a, mdl[ins[10:8]]);
      end
      4'ha: mdl[ins[10:8]] = (ins[11] ? mdl[13] : ((ia + 32'h4) & ~32'h2)) + off;
      4'hb:
      begin
        cnt = $countones(ins[8:0]);
        if (ins[11:8] == 4'h0)
          mdl[13] = ins[7] ? mdl[13] - {23'h0, ins[6:0], 2'b00} : mdl[13] + {23'h0, ins[6:0], 2'b00};
        else if (!ins[11])
        begin
          a = mdl[13] - 32'(4 * cnt);
          for (int j = 0; j < 8; j++) if (ins[j]) begin put(a, mdl[j]); a += 32'h4; end
          if (ins[8]) put(a, mdl[14]);
          mdl[13] -= 32'(4 * cnt);
        end
        else
        begin
          a = mdl[13];
          for (int j = 0; j < 8; j++) if (ins[j]) begin mdl[j] = rdMem(a); a += 32'h4; end
          if (ins[8]) expPc = rdMem(a);
          expR = ins[8];
          mdl[13] += 32'(4 * cnt);
        end
      end
      default:
      begin
        a = mdl[ins[10:8]];
        wb = a + 32'(4 * $countones(ins[7:0]));
        for (int j = 0; j < 8; j++)
        begin
          if (ins[j] && ins[11]) mdl[j] = rdMem(a);
          else if (ins[j]) put(a, mdl[j]);
          if (ins[j]) a += 32'h4;
        end
        // loaded base wins over write-back
        if (!(ins[11] && ins[ins[10:8]])) mdl[ins[10:8]] = wb;
      end
    endcase
  endtask : model

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (pcRedirect === 1'b1) redir++;
    if (cyc == 20000)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, cyc, 0);
      complete_run();
    end
  end

  // memory with random wait; released data lines show a changing pattern
  always @(posedge clk)
  begin
    if (memAck)
    begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
    else if (memReq.req === 1'b1)
    begin
      if (dly > 0) dly <= dly - 1;
      else
      begin
        memAck <= 1'b1;
        dly <= int'($urandom % 3);
        if (qA.size() == 0) chk(32'h1, 32'h0);
        else
        begin
          ma = qA.pop_front();
          mw = qW.pop_front();
          md = qD.pop_front();
          chk(memReq.addr, ma);
          chk({31'h0, memReq.wr}, {31'h0, mw});
          if (mw) chk(memReq.wdata, md);
          if (mw) mem[ma] = md;
          memRdata <= mw ? ~memRdata : mem[ma];
        end
      end
    end
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, memAck} = 5'h0;
    clkEn = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    memRdata = 32'h0;
    void'($urandom(45016));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (n = 0; n < 42; n++)
    begin
      s = n[3];
      w = (n < 7) ? 16'hffff : 16'($urandom);
      ia = (n < 7) ? 32'h0000_1002 : $urandom & ~32'h1;
      case (n % 7)
        0: ins = {4'h9, s, w[10:0]};
        1: ins = {4'ha, s, w[10:0]};
        2: ins = {8'hb0, s, w[6:0]};
        3: ins = {4'hb, 3'b010, w[8:0]};
        4: ins = {4'hb, 3'b110, w[8:0]};
        5:
        begin
          // keep base out of a store list, stored base value is not modelled
          ins = {4'hc, 1'b0, w[10:0]};
          ins[ins[10:8]] = 1'b0;
          if (ins[7:0] == 8'h00) ins[{ins[10:9], ~ins[8]}] = 1'b1;
        end
        default: ins = {4'hc, 1'b1, w[10:0]};
      endcase
      for (i = 0; i < 16; i++) ini[i] = $urandom;
      model();
      for (i = 0; i < 16; i++) apb(1'b1, ADDR_REG0 + 12'(4 * i), ini[i]);
      fl = $urandom & 32'h0000_000f;
      apb(1'b1, ADDR_IADDR, ia);
      apb(1'b1, ADDR_INSTR, {16'h0, ins});
      apb(1'b1, ADDR_FLAGS, fl);
      redir = 0;
      apb(1'b1, ADDR_CTRL, 32'h1);
      // enable low must hold the pending start
      clkEn <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      clkEn <= 1'b1;
      repeat (3) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      chk(32'(qA.size()), 32'h0);
      for (i = 0; i < 15; i++)
      begin
        apb(1'b0, ADDR_REG0 + 12'(4 * i), 32'h0);
        chk(rd, mdl[i]);
      end
      apb(1'b0, ADDR_FLAGS, 32'h0);
      chk(rd, fl);
      chk({31'h0, err}, 32'h0);
      chk(32'(redir), {31'h0, expR});
      if (expR) apb(1'b0, ADDR_PCOUT, 32'h0);
      if (expR) chk(rd, expPc);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ADDR_IADDR, 32'h0);
      chk(rd, ia);
    end
    // reset after the last run clears the register file
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_REG0 + 12'h034, 32'h0);
    chk(rd, RESET_WORD);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
